// file: design/rgx_rotate_exec.sv
// Rotate group execution unit with its register file and bus slave.
// Assumes an AXI4-Lite master and a memory that answers memReq with memAck.
// Operation
// - Opcode 17 rotates A left through carry in four states.
// - That rotate: carry gets old bit 7, H and N cleared, rest kept.
// - Opcode 1F rotates A right through carry in four states.
// - Right accumulator rotates: carry gets old bit 0, H,N cleared.
// - CB then 00000rrr rotates a register left circularly in eight states.
// - Register codes B..L are 000..101, A is 111, 110 means memory.
// - Circular left sets sign, zero, even parity; clears H,N; carry bit 7.
// - CB 06 rotates memory at the pointer pair in fifteen states.
// - DD CB d 06 rotates memory at first index plus displacement.
// - FD CB d 06 does the same with the second index register.
`timescale 1ns/1ps
`default_nettype none
module rgx_rotate_exec (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [rgx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rgx_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [rgx_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rgx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rgx_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic memReq,
  output logic memWe,
  output logic [rgx_pkg::MEM_AW-1:0] memAddr,
  output logic [rgx_pkg::BYTE_W-1:0] memWdata,
  input wire logic [rgx_pkg::BYTE_W-1:0] memRdata,
  input wire logic memAck
);
  import rgx_pkg::*;

  typedef struct packed {
    rgx_state_t state;
    logic [TCNT_W-1:0] count;
    logic rdDone;
    logic wrDone;
    logic done;
    logic illegal;
    logic [7:0][BYTE_W-1:0] gpr;
    logic [MEM_AW-1:0] idx1;
    logic [MEM_AW-1:0] idx2;
    logic [DATA_W-1:0] instr;
    logic [BYTE_W-1:0] memData;
    logic memReq;
    logic memWe;
    logic [MEM_AW-1:0] memAddr;
    logic [BYTE_W-1:0] memWdata;
    logic awGot;
    logic wGot;
    logic [ADDR_W-1:0] awAddr;
    logic [DATA_W-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } rgx_ctx_t;

  rgx_ctx_t ctx_reg;
  rgx_ctx_t ctx_next;
  logic rstSync_n;
  logic [BYTE_W-1:0] byte0;
  logic [BYTE_W-1:0] byte1;
  logic [BYTE_W-1:0] byte2;
  logic [BYTE_W-1:0] byte3;
  rgx_op_t decOp;
  logic [TCNT_W-1:0] decTotal;
  logic decMem;
  logic decIdx;
  logic decLegal;
  logic [REG_SEL_W-1:0] decReg;
  logic [MEM_AW-1:0] decAddr;
  logic [MEM_AW-1:0] dispExt;
  logic [BYTE_W-1:0] rotIn;
  logic [BYTE_W-1:0] rotResult;
  logic [BYTE_W-1:0] rotFlags;
  logic [DATA_W-1:0] rdWord;
  logic rdErr;
  logic startGo;
  logic finish;
  logic busy;

  function automatic logic [DATA_W-1:0] laneMerge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*BYTE_W +: BYTE_W] = data[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  rgx_reset_sync rgx_reset_sync_i (
    .clk(clk),
    .reset_n(reset_n),
    .rstSync_n(rstSync_n)
  );

  rgx_rotate_unit rgx_rotate_unit_i (
    .op(decOp),
    .operand(rotIn),
    .flagsIn(ctx_reg.gpr[REG_FLAGS]),
    .result(rotResult),
    .flagsOut(rotFlags)
  );

  assign byte0 = ctx_reg.instr[0*BYTE_W +: BYTE_W];
  assign byte1 = ctx_reg.instr[1*BYTE_W +: BYTE_W];
  assign byte2 = ctx_reg.instr[2*BYTE_W +: BYTE_W];
  assign byte3 = ctx_reg.instr[3*BYTE_W +: BYTE_W];
  assign dispExt = {{BYTE_W{byte2[BYTE_W-1]}}, byte2};
  assign busy = (ctx_reg.state == ST_RUN);

  // The instruction register is frozen while busy, so decode stays live.
  always_comb begin
    decOp = OP_NONE;
    decTotal = T_ACC;
    decMem = 1'b0;
    decIdx = 1'b0;
    decLegal = 1'b1;
    decReg = REG_A;
    decAddr = {ctx_reg.gpr[REG_H], ctx_reg.gpr[REG_L]};
    if (byte0 == OPC_ACC_LTC) begin
      decOp = OP_LTC;
    end else if (byte0 == OPC_ACC_RTC) begin
      decOp = OP_RTC;
    end else if (byte0 == OPC_ACC_RRC) begin
      decOp = OP_RRC;
    end else if (byte0 == PFX_BIT && byte1[7:3] == LCIRC_HI) begin
      decOp = OP_LCIRC;
      if (byte1[REG_SEL_W-1:0] == REG_MEM) begin
        decMem = 1'b1;
        decTotal = T_PTR;
      end else begin
        decReg = byte1[REG_SEL_W-1:0];
        decTotal = T_REG;
      end
    end else if ((byte0 == PFX_FIRST_IDX || byte0 == PFX_SECOND_IDX)
        && byte1 == PFX_BIT && byte3 == OPC_MEM_LCIRC) begin
      decOp = OP_LCIRC;
      decMem = 1'b1;
      decIdx = 1'b1;
      decTotal = T_IDX;
      if (byte0 == PFX_FIRST_IDX) begin
        decAddr = MEM_AW'(ctx_reg.idx1 + dispExt);
      end else begin
        decAddr = MEM_AW'(ctx_reg.idx2 + dispExt);
      end
    end else begin
      decLegal = 1'b0;
    end
  end

  assign rotIn = decMem ? ctx_reg.memData : ctx_reg.gpr[decReg];

  always_comb begin
    rdWord = '0;
    rdErr = 1'b0;
    if ((s_axi_araddr & GPR_MASK) == OFF_GPR) begin
      rdWord[BYTE_W-1:0] =
        ctx_reg.gpr[s_axi_araddr[GPR_IDX_LSB +: REG_SEL_W]];
    end else begin
      case (s_axi_araddr & WORD_MASK)
        OFF_CTRL: begin
        end
        OFF_STATUS: begin
          rdWord[STS_BUSY] = busy;
          rdWord[STS_DONE] = ctx_reg.done;
          rdWord[STS_ILLEGAL] = ctx_reg.illegal;
        end
        OFF_INSTR: rdWord = ctx_reg.instr;
        OFF_IDX1: rdWord[MEM_AW-1:0] = ctx_reg.idx1;
        OFF_IDX2: rdWord[MEM_AW-1:0] = ctx_reg.idx2;
        default: rdErr = 1'b1;
      endcase
    end
  end

  always_comb begin
    logic [DATA_W-1:0] merged;
    logic [ADDR_W-1:0] wa;
    logic idle;
    merged = '0;
    wa = ctx_reg.awAddr;
    idle = (ctx_reg.state == ST_IDLE);
    ctx_next = ctx_reg;
    startGo = 1'b0;
    finish = 1'b0;
    if (s_axi_awvalid && !ctx_reg.awGot) begin
      ctx_next.awGot = 1'b1;
      ctx_next.awAddr = s_axi_awaddr & WORD_MASK;
    end
    if (s_axi_wvalid && !ctx_reg.wGot) begin
      ctx_next.wGot = 1'b1;
      ctx_next.wData = s_axi_wdata;
      ctx_next.wStrb = s_axi_wstrb;
    end
    if (ctx_reg.bValid && s_axi_bready) begin
      ctx_next.bValid = 1'b0;
    end
    // Register writes land only while idle, so they never race execution.
    if (ctx_reg.awGot && ctx_reg.wGot && !ctx_reg.bValid) begin
      ctx_next.awGot = 1'b0;
      ctx_next.wGot = 1'b0;
      ctx_next.bValid = 1'b1;
      ctx_next.bResp = RESP_OKAY;
      if ((wa & GPR_MASK) == OFF_GPR) begin
        if (idle && ctx_reg.wStrb[0]) begin
          ctx_next.gpr[wa[GPR_IDX_LSB +: REG_SEL_W]] =
            ctx_reg.wData[BYTE_W-1:0];
        end
      end else begin
        case (wa)
          OFF_CTRL: begin
            if (idle && ctx_reg.wStrb[0] && ctx_reg.wData[CTRL_START]) begin
              ctx_next.done = 1'b0;
              ctx_next.illegal = !decLegal;
              if (decLegal) begin
                startGo = 1'b1;
                ctx_next.state = ST_RUN;
                ctx_next.count = '0;
                ctx_next.rdDone = 1'b0;
                ctx_next.wrDone = 1'b0;
              end
            end
          end
          OFF_STATUS: begin
          end
          OFF_INSTR: begin
            if (idle) begin
              ctx_next.instr =
                laneMerge(ctx_reg.instr, ctx_reg.wData, ctx_reg.wStrb);
            end
          end
          OFF_IDX1: begin
            if (idle) begin
              merged = laneMerge(DATA_W'(ctx_reg.idx1), ctx_reg.wData,
                ctx_reg.wStrb);
              ctx_next.idx1 = merged[MEM_AW-1:0];
            end
          end
          OFF_IDX2: begin
            if (idle) begin
              merged = laneMerge(DATA_W'(ctx_reg.idx2), ctx_reg.wData,
                ctx_reg.wStrb);
              ctx_next.idx2 = merged[MEM_AW-1:0];
            end
          end
          default: ctx_next.bResp = RESP_SLVERR;
        endcase
      end
    end
    if (s_axi_arvalid && !ctx_reg.rValid) begin
      ctx_next.rValid = 1'b1;
      ctx_next.rData = rdWord;
      ctx_next.rResp = rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (ctx_reg.rValid && s_axi_rready) begin
      ctx_next.rValid = 1'b0;
    end
    unique case (ctx_reg.state)
      ST_IDLE: begin
      end
      ST_RUN: begin
        if (decMem && !ctx_reg.rdDone
            && ctx_reg.count == TCNT_W'(decTotal - T_RD_BACK)) begin
          if (!ctx_reg.memReq) begin
            ctx_next.memReq = 1'b1;
            ctx_next.memWe = 1'b0;
            ctx_next.memAddr = decAddr;
          end else if (memAck) begin
            ctx_next.memReq = 1'b0;
            ctx_next.memData = memRdata;
            ctx_next.rdDone = 1'b1;
            ctx_next.count = TCNT_W'(ctx_reg.count + T_STEP);
          end
        end else if (decMem && !ctx_reg.wrDone
            && ctx_reg.count == TCNT_W'(decTotal - T_WR_BACK)) begin
          if (!ctx_reg.memReq) begin
            ctx_next.memReq = 1'b1;
            ctx_next.memWe = 1'b1;
            ctx_next.memAddr = decAddr;
            ctx_next.memWdata = rotResult;
          end else if (memAck) begin
            ctx_next.memReq = 1'b0;
            ctx_next.memWe = 1'b0;
            ctx_next.wrDone = 1'b1;
            ctx_next.count = TCNT_W'(ctx_reg.count + T_STEP);
          end
        end else if (ctx_reg.count == TCNT_W'(decTotal - T_STEP)) begin
          finish = 1'b1;
          if (!decMem) begin
            ctx_next.gpr[decReg] = rotResult;
          end
          ctx_next.gpr[REG_FLAGS] = rotFlags;
          ctx_next.state = ST_IDLE;
          ctx_next.done = 1'b1;
          ctx_next.count = '0;
        end else begin
          ctx_next.count = TCNT_W'(ctx_reg.count + T_STEP);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctx_reg <= '0;
    end else begin
      ctx_reg <= ctx_next;
    end
  end

  assign s_axi_awready = !ctx_reg.awGot;
  assign s_axi_wready = !ctx_reg.wGot;
  assign s_axi_bvalid = ctx_reg.bValid;
  assign s_axi_bresp = ctx_reg.bResp;
  assign s_axi_arready = !ctx_reg.rValid;
  assign s_axi_rvalid = ctx_reg.rValid;
  assign s_axi_rdata = ctx_reg.rData;
  assign s_axi_rresp = ctx_reg.rResp;
  assign memReq = ctx_reg.memReq;
  assign memWe = ctx_reg.memWe;
  assign memAddr = ctx_reg.memAddr;
  assign memWdata = ctx_reg.memWdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync_n);

  sequence accRun;
    busy [*4] ##1 !busy;
  endsequence
  sequence regRun;
    busy [*8] ##1 !busy;
  endsequence
  sequence wrAck;
    memReq && memWe && memAck;
  endsequence

  accTiming_a: assert property (
    startGo && decOp != OP_LCIRC |=> accRun)
    else $error("accumulator rotate not four states");
  // Undefined flag bits 5 and 3 are carried through unchanged.
  ltcFlags_a: assert property (
    finish && decOp == OP_LTC |=>
    ctx_reg.gpr[REG_A] == {$past(ctx_reg.gpr[REG_A][6:0]),
      $past(ctx_reg.gpr[REG_FLAGS][FLAG_C])}
    && ctx_reg.gpr[REG_FLAGS] ==
      (($past(ctx_reg.gpr[REG_FLAGS]) & 8'hEC)
      | {7'h00, $past(ctx_reg.gpr[REG_A][7])}))
    else $error("left through carry result or flags wrong");
  rtcValue_a: assert property (
    finish && decOp == OP_RTC |=>
    ctx_reg.gpr[REG_A] == {$past(ctx_reg.gpr[REG_FLAGS][FLAG_C]),
      $past(ctx_reg.gpr[REG_A][7:1])})
    else $error("right through carry result wrong");
  rightFlags_a: assert property (
    finish && (decOp == OP_RTC || decOp == OP_RRC) |=>
    ctx_reg.gpr[REG_FLAGS] ==
      (($past(ctx_reg.gpr[REG_FLAGS]) & 8'hEC)
      | {7'h00, $past(ctx_reg.gpr[REG_A][0])}))
    else $error("right rotate flags wrong");
  rrcValue_a: assert property (
    finish && decOp == OP_RRC |=>
    ctx_reg.gpr[REG_A] == {$past(ctx_reg.gpr[REG_A][0]),
      $past(ctx_reg.gpr[REG_A][7:1])})
    else $error("right circular result wrong");
  regTiming_a: assert property (
    startGo && decOp == OP_LCIRC && !decMem |=> regRun)
    else $error("register rotate not eight states");
  regWrite_a: assert property (
    finish && decOp == OP_LCIRC && !decMem |=>
    ctx_reg.gpr[decReg] == {$past(rotIn[6:0]), $past(rotIn[7])})
    else $error("wrong register written");
  lcircFlags_a: assert property (
    finish && decOp == OP_LCIRC |=>
    ctx_reg.gpr[REG_FLAGS][FLAG_S] == $past(rotIn[6])
    && ctx_reg.gpr[REG_FLAGS][FLAG_Z] == ($past(rotIn) == 8'h00)
    && ctx_reg.gpr[REG_FLAGS][FLAG_PV] == ~^$past(rotIn)
    && ctx_reg.gpr[REG_FLAGS][FLAG_C] == $past(rotIn[7])
    && !ctx_reg.gpr[REG_FLAGS][FLAG_H] && !ctx_reg.gpr[REG_FLAGS][FLAG_N])
    else $error("circular left flags wrong");
  ptrAddr_a: assert property (
    memReq && !decIdx |->
    memAddr == {ctx_reg.gpr[REG_H], ctx_reg.gpr[REG_L]})
    else $error("pointer pair address wrong");
  firstIdx_a: assert property (
    memReq && decIdx && byte0 == PFX_FIRST_IDX |->
    memAddr == MEM_AW'(ctx_reg.idx1 + dispExt))
    else $error("first index address wrong");
  secondIdx_a: assert property (
    memReq && decIdx && byte0 == PFX_SECOND_IDX |->
    memAddr == MEM_AW'(ctx_reg.idx2 + dispExt))
    else $error("second index address wrong");
  writeBack_a: assert property (
    wrAck |-> ctx_reg.rdDone && memWdata == rotResult
    ##1 !memReq ##1 finish)
    else $error("memory write back out of order");
endmodule
`default_nettype wire

// file: design/rgx_pkg.sv
// Constants and types shared by the rotate group execution block.
// Assumes a byte-wide processor memory port and a 32-bit register bus.
package rgx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;
  localparam int MEM_AW = 16;
  localparam int TCNT_W = 5;
  localparam int REG_SEL_W = 3;
  localparam int GPR_IDX_LSB = 2;

  localparam logic [7:0] WORD_MASK = 8'hFC;
  localparam logic [7:0] GPR_MASK = 8'hE0;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_GPR = 8'h20;
  localparam logic [7:0] OFF_IDX1 = 8'h40;
  localparam logic [7:0] OFF_IDX2 = 8'h44;

  localparam int CTRL_START = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_ILLEGAL = 2;

  localparam logic [7:0] OPC_ACC_LTC = 8'h17;
  localparam logic [7:0] OPC_ACC_RTC = 8'h1F;
  localparam logic [7:0] OPC_ACC_RRC = 8'h0F;
  localparam logic [7:0] PFX_BIT = 8'hCB;
  localparam logic [7:0] PFX_FIRST_IDX = 8'hDD;
  localparam logic [7:0] PFX_SECOND_IDX = 8'hFD;
  localparam logic [7:0] OPC_MEM_LCIRC = 8'h06;
  localparam logic [4:0] LCIRC_HI = 5'h00;

  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_FLAGS = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;

  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;

  localparam logic [4:0] T_ACC = 5'h04;
  localparam logic [4:0] T_REG = 5'h08;
  localparam logic [4:0] T_PTR = 5'h0F;
  localparam logic [4:0] T_IDX = 5'h17;
  localparam logic [4:0] T_RD_BACK = 5'h07;
  localparam logic [4:0] T_WR_BACK = 5'h03;
  localparam logic [4:0] T_STEP = 5'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LTC = 3'b001,
    OP_RTC = 3'b010,
    OP_RRC = 3'b011,
    OP_LCIRC = 3'b100
  } rgx_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } rgx_state_t;
endpackage

// file: design/rgx_reset_sync.sv
// Releases the external reset through two flip-flops.
// Assumes reset_n may rise at any moment relative to clk.
`timescale 1ns/1ps
`default_nettype none
module rgx_reset_sync (
  input wire logic clk,
  input wire logic reset_n,
  output logic rstSync_n
);
  logic [1:0] sync_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], 1'b1};
    end
  end

  assign rstSync_n = sync_reg[1];
endmodule
`default_nettype wire

// file: design/rgx_rotate_unit.sv
// Combinational rotate datapath and flag update for one byte.
// Assumes the caller holds operand and flags stable while it reads them.
`timescale 1ns/1ps
`default_nettype none
module rgx_rotate_unit (
  input wire rgx_pkg::rgx_op_t op,
  input wire logic [rgx_pkg::BYTE_W-1:0] operand,
  input wire logic [rgx_pkg::BYTE_W-1:0] flagsIn,
  output logic [rgx_pkg::BYTE_W-1:0] result,
  output logic [rgx_pkg::BYTE_W-1:0] flagsOut
);
  import rgx_pkg::*;

  always_comb begin
    result = operand;
    flagsOut = flagsIn;
    unique case (op)
      OP_LTC: begin
        result = {operand[BYTE_W-2:0], flagsIn[FLAG_C]};
        flagsOut[FLAG_C] = operand[BYTE_W-1];
      end
      OP_RTC: begin
        result = {flagsIn[FLAG_C], operand[BYTE_W-1:1]};
        flagsOut[FLAG_C] = operand[0];
      end
      OP_RRC: begin
        result = {operand[0], operand[BYTE_W-1:1]};
        flagsOut[FLAG_C] = operand[0];
      end
      OP_LCIRC: begin
        result = {operand[BYTE_W-2:0], operand[BYTE_W-1]};
        flagsOut[FLAG_C] = operand[BYTE_W-1];
        flagsOut[FLAG_S] = result[BYTE_W-1];
        flagsOut[FLAG_Z] = (result == '0);
        flagsOut[FLAG_PV] = ~^result;
      end
      OP_NONE: begin
      end
      default: begin
      end
    endcase
    if (op != OP_NONE) begin
      flagsOut[FLAG_H] = 1'b0;
      flagsOut[FLAG_N] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_rgx_rotate_exec.sv
// Self-checking bench for the rotate group execution unit.
// Assumes the unit answers each memory cycle after a one-cycle memAck.
`timescale 1ns/1ps
`default_nettype none
module tb_rgx_rotate_exec;
  import rgx_pkg::*;
  logic clk, reset_n;
  logic [7:0] awaddr, araddr, memWdata, memRdata, opnd;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic memReq, memWe, memAck;
  logic [15:0] memAddr, rdAddr, wrAddr;
  logic [7:0] wrData, v, res;
  int nRd, nWr, rd0, wr0, nFail, checksDone;
  // Each entry: opcode, A in, F in, A out, F out under mask D7.
  localparam logic [39:0] ACC_T [6] = '{40'h1776FFEDC4, 40'h1780000001,
    40'h1FE1007001, 40'h1F02FF81C4, 40'h0F01008001, 40'h0FFEFF7FC4};
  // Each entry: instruction, address, operand, result, F out.
  localparam logic [71:0] MEM_T [4] = '{72'h000006CB_2828_88_11_05,
    72'h0602CBDD_1002_00_00_44, 72'h06FECBFD_0FFE_F0_E1_85,
    72'h0680CBDD_0F80_01_02_00};

  rgx_rotate_exec rgx_rotate_exec_i (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read data toggles every cycle outside a request, so a sample one cycle late cannot match.
  always @(posedge clk) begin
    if (memReq && !memAck) begin
      memAck <= 1'b1;
      if (memWe) begin
        wrAddr <= memAddr;
        wrData <= memWdata;
        nWr <= nWr + 1;
      end else begin
        memRdata <= opnd;
        rdAddr <= memAddr;
        nRd <= nRd + 1;
      end
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] dt,
                          output logic [1:0] rs);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] dt,
                         output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic [1:0] rs;
    axiWrite(a, dt, rs);
  endtask

  // Polls until the unit leaves busy; the bound keeps a stuck unit short.
  task automatic runInstr(input logic [31:0] ins, input logic [2:0] sts,
                          input bit chkBusy);
    int n;
    n = 0;
    wr(OFF_INSTR, ins);
    wr(OFF_CTRL, 32'h00000001);
    do begin
      axiRead(OFF_STATUS, d, r);
      if (n == 0 && chkBusy) check(d & 32'h1, 32'h1); // busy seen
      n++;
    end while (d[STS_BUSY] === 1'b1 && n < 100);
    check(d & 32'h7, {29'h0, sts});
  endtask

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    nFail++;
    printVerdict();
  end

  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {nFail, checksDone} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h0);
    axiRead(OFF_GPR + 8'h1C, d, r);
    check(d, 32'h0);
    axiRead(8'h80, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axiWrite(8'h80, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axiWrite(OFF_STATUS, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    $display("test reset done");
    foreach (ACC_T[i]) begin
      wr(OFF_GPR + 8'h1C, {24'h0, ACC_T[i][31:24]});
      wr(OFF_GPR + 8'h18, {24'h0, ACC_T[i][23:16]});
      runInstr({24'h0, ACC_T[i][39:32]}, 3'h2, 1'b0);
      axiRead(OFF_GPR + 8'h1C, d, r);
      check(d, {24'h0, ACC_T[i][15:8]});
      axiRead(OFF_GPR + 8'h18, d, r);
      check(d & 32'hD7, {24'h0, ACC_T[i][7:0]});
    end
    $display("test accumulator done");
    for (int i = 0; i < 16; i++) begin
      if (i[2:0] != REG_MEM) begin
        v = i[3] ? 8'h00 : (8'hC0 | {5'h0, i[2:0]});
        res = {v[6:0], v[7]};
        wr(OFF_GPR + 8'h18, 32'h00000052);
        wr(OFF_GPR + {3'h0, i[2:0], 2'h0}, {24'h0, v});
        runInstr({16'h0, 5'h0, i[2:0], PFX_BIT}, 3'h2, 1'b1);
        axiRead(OFF_GPR + {3'h0, i[2:0], 2'h0}, d, r);
        check(d, {24'h0, res});
        axiRead(OFF_GPR + 8'h18, d, r);
        check(d & 32'hD7, {24'h0, res[7], res == 8'h0, 3'h0, ~^res,
                           1'b0, v[7]});
      end
    end
    $display("test register done");
    // undefined encodings set the illegal flag
    runInstr(32'h000008CB, 3'h4, 1'b0);
    runInstr(32'h00000000, 3'h4, 1'b0);
    $display("test illegal done");
    wr(OFF_GPR + 8'h10, 32'h00000028);
    wr(OFF_GPR + 8'h14, 32'h00000028);
    wr(OFF_IDX1, 32'h00001000);
    wr(OFF_IDX2, 32'h00001000);
    foreach (MEM_T[i]) begin
      opnd = MEM_T[i][23:16];
      rd0 = nRd;
      wr0 = nWr;
      runInstr(MEM_T[i][71:40], 3'h2, 1'b1);
      check({16'(nRd - rd0), 16'(nWr - wr0)}, 32'h00010001);
      check({rdAddr, wrAddr}, {2{MEM_T[i][39:24]}});
      check({24'h0, wrData}, {24'h0, MEM_T[i][15:8]});
      axiRead(OFF_GPR + 8'h18, d, r);
      check(d & 32'hD7, {24'h0, MEM_T[i][7:0]});
    end
    $display("test memory done");
    printVerdict();
  end
endmodule
`default_nettype wire
